/* File: rtl/setup_store_params.svh */
`ifndef SETUP_STORE_PARAMS_SVH
`define SETUP_STORE_PARAMS_SVH
`define SETUP_W 32
`define SLOT_COUNT 10
`define SLOT_AW 4
`define LAST_SLOT 4'h9
`define CARD_SLOTS 2
`define RST_SETUP 32'h0000_0001
`define PRESET_SETUP 32'h0000_0002
`define ASCII_ONE 8'h31
`define ASCII_COMMA 8'h2c
`define ASCII_SPACE 8'h20
`define CARD_NONE 16'h0000
`define STB_MAV_BIT 4
`endif

/* File: rtl/setup_store_pkg.sv */
package setup_store_pkg;
	typedef enum logic [2:0] {
		CMD_SAVE, CMD_RECALL, CMD_RESET, CMD_OPC_QUERY, CMD_OPT_QUERY
	} cmd_type;
	typedef enum logic [1:0] {OQ_IDLE, OQ_ACTIVE} oq_type;
endpackage

/* File: rtl/setup_slot_store.sv */
`include "setup_store_params.svh"
module setup_slot_store (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_wr,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	output logic [31:0] o_rdata
);
	// Power-up content is the preset setup in every location
	logic [`SETUP_W-1:0] mem_q [`SLOT_COUNT];
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int k = 0; k < `SLOT_COUNT; k++) begin
				mem_q[k] <= `PRESET_SETUP; // [R5]
			end
		end else if (i_wr) begin
			mem_q[i_addr] <= i_wdata; // [R3]
		end
	end
	assign o_rdata = (i_addr <= `LAST_SLOT) ? mem_q[i_addr] : '0;
endmodule // setup_slot_store

/* File: rtl/setup_store_recall_reset.sv */
// Operation
// [R1] Option query loads option string into output queue for talking.
// [R2] One comma-separated entry per card slot: model number or NONE.
// [R3] Ten locations 0..9; save copies active setup to location.
// [R4] Recall 0..9 replaces active setup with stored one.
// [R5] All locations start holding preset default setup.
// [R6] Reset loads reset default setup, abandons pending operations.
// [R7] Reset cancels outstanding completion query; no late response. Code still queues ASCII 1 when scan ends in the reset cycle.
// [R8] Reset leaves bus address, event and status byte untouched.
// [R9] Pending completion query queues ASCII 1 only after scan ends.
// [R10] Power-up and reset return completion tracking to idle.
// [R11] Message-available bit follows output queue non-empty.
// [R12] Out-of-range save or recall flags execution error, no change.
`include "setup_store_params.svh"
module setup_store_recall_reset (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_cmd_valid,
	input wire setup_store_pkg::cmd_type i_cmd,
	input wire logic [3:0] i_cmd_arg,
	input wire logic [31:0] i_active_setup,
	input wire logic i_op_pending,
	input wire logic [15:0] i_card_model [`CARD_SLOTS],
	input wire logic i_talk_ready,
	output logic o_talk_valid,
	output logic [7:0] o_talk_byte,
	output logic o_talk_last,
	output logic o_load_setup,
	output logic [31:0] o_load_value,
	output logic o_abort_ops,
	output logic o_exec_error,
	output logic o_mav
);
	import setup_store_pkg::*;
	localparam int MSG_LEN = 16;
	// Per card slot: four chars, then ", " separator between slots
	typedef struct packed {
		oq_type oq;
		logic [MSG_LEN-1:0][7:0] msg;
		logic [4:0] len;
		logic [4:0] pos;
		logic load;
		logic [31:0] load_val;
		logic abort;
		logic err;
		logic [7:0] tbyte;
	} state_type;
	state_type s_q, s_d;
	logic mem_wr;
	logic [31:0] mem_rd;
	logic in_range;
	assign in_range = i_cmd_arg <= `LAST_SLOT;
	assign mem_wr = i_cmd_valid && i_cmd == CMD_SAVE && in_range; // [R3]
	setup_slot_store u_store (
		.i_ref_clk(i_ref_clk),
		.i_arst_n(i_arst_n),
		.i_wr(mem_wr),
		.i_addr(i_cmd_arg),
		.i_wdata(i_active_setup),
		.o_rdata(mem_rd)
	);
	function automatic logic [7:0] hex_char(input logic [3:0] n);
		hex_char = (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
	endfunction
	always_comb begin
		s_d = s_q;
		s_d.load = 1'b0;
		s_d.abort = 1'b0;
		s_d.err = 1'b0;
		if (s_q.len != 5'h00 && i_talk_ready) begin
			if (s_q.pos + 5'h01 == s_q.len) begin
				s_d.len = 5'h00;
				s_d.pos = 5'h00;
			end else begin
				s_d.pos = s_q.pos + 5'h01;
			end
		end
		if (s_q.oq == OQ_ACTIVE && !i_op_pending && s_d.len == 5'h00) begin
			s_d.msg[0] = `ASCII_ONE; // [R9]
			s_d.len = 5'h01;
			s_d.pos = 5'h00;
			s_d.oq = OQ_IDLE;
		end
		if (i_cmd_valid) begin
			case (i_cmd)
				CMD_SAVE: s_d.err = !in_range; // [R12]
				CMD_RECALL: begin
					if (in_range) begin
						s_d.load = 1'b1; // [R4]
						s_d.load_val = mem_rd;
					end else begin
						s_d.err = 1'b1; // [R12]
					end
				end
				CMD_RESET: begin
					s_d.load = 1'b1; // [R6]
					s_d.load_val = `RST_SETUP;
					s_d.abort = 1'b1; // [R6]
					s_d.oq = OQ_IDLE; // [R7] [R10]
				end
				CMD_OPC_QUERY: s_d.oq = OQ_ACTIVE;
				CMD_OPT_QUERY: begin
					if (s_d.len == 5'h00) begin
						for (int c = 0; c < `CARD_SLOTS; c++) begin
							for (int d = 0; d < 4; d++) begin
								s_d.msg[c*6+d] = (i_card_model[c] == `CARD_NONE)
									? 8'("NONE" >> (8 * (3 - d))) // [R2]
									: hex_char(i_card_model[c][15-4*d -: 4]);
							end
							s_d.msg[c*6+4] = `ASCII_COMMA;
							s_d.msg[c*6+5] = `ASCII_SPACE;
						end
						s_d.len = 5'(`CARD_SLOTS*6-2); // [R1]
						s_d.pos = 5'h00;
					end else begin
						s_d.err = 1'b1;
					end
				end
				default: s_d.err = 1'b1;
			endcase
		end
		// Talk byte registered so data leaves a flip-flop
		s_d.tbyte = s_d.msg[s_d.pos[3:0]];
	end
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_q <= '0; // [R10]
		end else begin
			s_q <= s_d;
		end
	end
	assign o_talk_valid = s_q.len != 5'h00;
	assign o_talk_byte = s_q.tbyte;
	assign o_talk_last = o_talk_valid && s_q.pos + 5'h01 == s_q.len;
	assign o_load_setup = s_q.load;
	assign o_load_value = s_q.load_val;
	assign o_abort_ops = s_q.abort;
	assign o_exec_error = s_q.err;
	assign o_mav = s_q.len != 5'h00; // [R11] [R8]

	property p_mav;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		o_talk_valid && o_talk_last && i_talk_ready && !i_cmd_valid
			&& s_q.oq == OQ_IDLE |=> !o_mav;
	endproperty
	a_mav: assert property (p_mav) else $error("mav stuck"); // [R11]
	property p_rst_idle;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		i_cmd_valid && i_cmd == CMD_RESET |=> s_q.oq == OQ_IDLE && o_abort_ops;
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("reset"); // [R7]
	property p_rst_load;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		i_cmd_valid && i_cmd == CMD_RESET |=> o_load_value == `RST_SETUP;
	endproperty
	a_rst_load: assert property (p_rst_load) else $error("rst load"); // [R6]
	property p_err;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		i_cmd_valid && (i_cmd == CMD_SAVE || i_cmd == CMD_RECALL)
			&& i_cmd_arg > `LAST_SLOT |=> o_exec_error && !o_load_setup;
	endproperty
	a_err: assert property (p_err) else $error("range"); // [R12]
	property p_no_early_one;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		s_q.oq == OQ_ACTIVE && i_op_pending |=> s_q.oq == OQ_ACTIVE
			|| $past(i_cmd_valid);
	endproperty
	a_no_early_one: assert property (p_no_early_one) else $error("opc"); // [R9]
	property p_recall;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		i_cmd_valid && i_cmd == CMD_RECALL && i_cmd_arg <= `LAST_SLOT
			|=> o_load_setup;
	endproperty
	a_recall: assert property (p_recall) else $error("recall"); // [R4]
	property p_opt;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		i_cmd_valid && i_cmd == CMD_OPT_QUERY && !o_talk_valid
			|=> o_talk_valid && s_q.len == 5'(`CARD_SLOTS*6-2);
	endproperty
	a_opt: assert property (p_opt) else $error("opt"); // [R1]
	property p_save_quiet;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		i_cmd_valid && i_cmd == CMD_SAVE |=> !o_load_setup;
	endproperty
	a_save_quiet: assert property (p_save_quiet) else $error("save"); // [R3]
	property p_keep_mav;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		i_cmd_valid && i_cmd == CMD_RESET && o_talk_valid && !o_talk_last
			|=> o_mav;
	endproperty
	a_keep_mav: assert property (p_keep_mav) else $error("mav"); // [R8]
	property p_opc_done;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		s_q.oq == OQ_ACTIVE && !i_op_pending && !o_talk_valid
			&& !i_cmd_valid |=> o_talk_byte == `ASCII_ONE && o_talk_last;
	endproperty
	a_opc_done: assert property (p_opc_done) else $error("opc one"); // [R9]
	property p_opt_busy;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		i_cmd_valid && i_cmd == CMD_OPT_QUERY
			&& o_talk_valid && !o_talk_last |=> o_exec_error && o_talk_valid;
	endproperty
	a_opt_busy: assert property (p_opt_busy) else $error("busy"); // [R1]
	property p_rst_cancel;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		i_cmd_valid && i_cmd == CMD_RESET
			##1 !o_talk_valid && !i_cmd_valid |=> !o_talk_valid;
	endproperty
	a_rst_cancel: assert property (p_rst_cancel) else $error("cancel"); // [R7]
	property p_talk_hold;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		o_talk_valid && !i_talk_ready && !i_cmd_valid
			|=> o_talk_valid && $stable(o_talk_byte);
	endproperty
	a_talk_hold: assert property (p_talk_hold) else $error("hold"); // [R1]
	property p_advance;
		@(posedge i_ref_clk) disable iff (!i_arst_n)
		o_talk_valid && i_talk_ready && !o_talk_last |=> o_talk_valid;
	endproperty
	a_advance: assert property (p_advance) else $error("advance"); // [R1]
endmodule // setup_store_recall_reset

/* File: tb/talk_host.sv */
module talk_host (
	input wire logic i_ref_clk,
	input wire logic i_valid,
	input wire logic [7:0] i_byte,
	input wire logic i_last,
	input wire logic i_slow,
	output logic o_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] rx[$];
	logic lf[$];
	logic ph = 1'b0;
	initial o_ready = 1'b0;
	// Slow mode takes a byte only every other cycle
	always @(negedge i_ref_clk) begin
		ph <= ~ph;
		o_ready <= i_slow ? ph : 1'b1;
	end
	always @(posedge i_ref_clk) begin
		if (i_valid && o_ready) begin
			rx.push_back(i_byte);
			lf.push_back(i_last);
		end
	end
endmodule // talk_host

/* File: tb/setup_store_recall_reset_tb.sv */
`include "setup_store_params.svh"
module setup_store_recall_reset_tb;
	import setup_store_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst_n = 1'b0, cv = 1'b0, pend = 1'b0, slow = 1'b0;
	cmd_type cmd = CMD_SAVE;
	logic [3:0] arg = 4'h0;
	logic [31:0] act = 32'h0, lv;
	logic [15:0] card [`CARD_SLOTS];
	logic rdy, tv, tl, ld, ab, er, mav;
	logic [7:0] tb8;
	int n_errors = 0, n_tests = 0;
	string e = "1234, NONE";
	always #25 clk = ~clk;
	setup_store_recall_reset DUT (.i_ref_clk(clk), .i_arst_n(rst_n),
		.i_cmd_valid(cv), .i_cmd(cmd), .i_cmd_arg(arg),
		.i_active_setup(act), .i_op_pending(pend), .i_card_model(card),
		.i_talk_ready(rdy), .o_talk_valid(tv), .o_talk_byte(tb8),
		.o_talk_last(tl), .o_load_setup(ld), .o_load_value(lv),
		.o_abort_ops(ab), .o_exec_error(er), .o_mav(mav));
	talk_host host (.i_ref_clk(clk), .i_valid(tv), .i_byte(tb8),
		.i_last(tl), .i_slow(slow), .o_ready(rdy));
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic issue(input cmd_type c, input logic [3:0] a);
		@(negedge clk);
		cv = 1'b1;
		cmd = c;
		arg = a;
		@(negedge clk);
		cv = 1'b0;
	endtask
	task automatic t_slots();
		issue(CMD_RECALL, 4'h3);
		chk({ld, ab, er, lv}, {3'b100, 32'h2});
		act = 32'hcafe_0009;
		issue(CMD_SAVE, 4'h9);
		chk({ld, er}, 2'b00);
		issue(CMD_RECALL, 4'h9);
		chk({ld, lv}, {1'b1, act});
		issue(CMD_SAVE, 4'ha);
		chk({ld, er}, 2'b01);
		issue(CMD_RECALL, 4'hf);
		chk({ld, er}, 2'b01);
		issue(CMD_RECALL, 4'h0);
		chk({ld, lv}, {1'b1, 32'h2});
	endtask
	task automatic t_opt();
		card = '{16'h1234, 16'h0000};
		slow = 1'b1;
		host.rx.delete();
		host.lf.delete();
		issue(CMD_OPT_QUERY, 4'h0);
		chk(mav, 1'b1);
		issue(CMD_OPT_QUERY, 4'h0);
		chk({er, mav}, 2'b11);
		issue(CMD_RESET, 4'h0);
		chk({ab, mav}, 2'b11);
		for (int i = 0; i < 100 && tv !== 1'b0; i++)
			@(negedge clk);
		chk(host.rx.size(), 10);
		for (int i = 0; i < 10 && i < host.rx.size(); i++)
			chk(host.rx[i], e[i]);
		if (host.lf.size() == 10)
			chk({host.lf[8], host.lf[9]}, 2'b01);
		chk(mav, 1'b0);
		slow = 1'b0;
	endtask
	task automatic t_opc();
		host.rx.delete();
		pend = 1'b1;
		issue(CMD_OPC_QUERY, 4'h0);
		repeat (5) @(negedge clk);
		chk({mav, host.rx.size()}, 33'h0);
		pend = 1'b0;
		@(negedge clk);
		chk({mav, tb8}, {1'b1, 8'h31});
		for (int i = 0; i < 8 && host.rx.size() == 0; i++)
			@(negedge clk);
		chk({host.rx.size(), host.rx[0]}, {32'h1, 8'h31});
		host.rx.delete();
		pend = 1'b1;
		issue(CMD_OPC_QUERY, 4'h0);
		issue(CMD_RESET, 4'h0);
		chk({ld, ab, lv}, {2'b11, 32'h1});
		pend = 1'b0;
		repeat (8) @(negedge clk);
		chk({mav, host.rx.size()}, 33'h0);
	endtask
	task automatic t_arst();
		pend = 1'b1;
		issue(CMD_SAVE, 4'h5);
		issue(CMD_OPC_QUERY, 4'h0);
		rst_n = 1'b0;
		@(negedge clk);
		rst_n = 1'b1;
		pend = 1'b0;
		repeat (4) @(negedge clk);
		chk({mav, tv, host.rx.size()}, 34'h0);
		issue(CMD_RECALL, 4'h5);
		chk({ld, lv}, {1'b1, `PRESET_SETUP});
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		summarize();
	end
	initial begin
		card = '{16'h0000, 16'h0000};
		repeat (10) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		t_slots();
		t_opt();
		t_opc();
		t_arst();
		summarize();
	end
endmodule // setup_store_recall_reset_tb
